// file: src/brbc_map.svh
// Register offsets, field layouts, reset values and timing counts for the boot and cache control.
`ifndef BRBC_MAP_SVH
`define BRBC_MAP_SVH

`define BRBC_ADDR_W          12
`define BRBC_OFF_SUACR       12'h000
`define BRBC_OFF_CACHE_CTRL  12'h004
`define BRBC_OFF_CACHE_STAT  12'h008
`define BRBC_OFF_WIN_A_START 12'h00c
`define BRBC_OFF_WIN_A_END   12'h010
`define BRBC_OFF_WIN_B_START 12'h014
`define BRBC_OFF_WIN_B_END   12'h018
`define BRBC_OFF_WIN_EN      12'h01c
`define BRBC_OFF_BOOT_BANK_SELECT_REG     12'h020
`define BRBC_OFF_CLK_MHZ     12'h024
`define BRBC_OFF_DF_WAIT     12'h028
`define BRBC_OFF_IRQ_STAT    12'h02c
`define BRBC_OFF_IRQ_MASK    12'h030
`define BRBC_OFF_BOOT_STAT   12'h034

`define BRBC_SAS_RESET       2'h0
`define BRBC_BOOT_BANK_SELECT_REG_RESET   1'h1
`define BRBC_CLK_RESET       8'h20
`define BRBC_DF_WAIT_RESET   2'h1
`define BRBC_DF_THRESH1      8'h20
`define BRBC_DF_THRESH2      8'h3c
`define BRBC_DF_THRESH3      8'h50

`define BRBC_BANK_WRITE_NS   40
`define BRBC_CLK_NS          4
`define BRBC_BANK_WRITE_CYC  ((`BRBC_BANK_WRITE_NS + `BRBC_CLK_NS - 1) / `BRBC_CLK_NS)
`define BRBC_CACHE_HOLD_CYC  4

`define BRBC_IRQ_BANK_DONE   0
`define BRBC_IRQ_CLK_DONE    1
`define BRBC_IRQ_W           2

`endif

// file: src/brbc_pkg.sv
// Types shared by the boot region, bank and cache control block.
package brbc_pkg;
  typedef enum logic [1:0] {
    brbc_sas_follow = 2'h0,
    brbc_sas_zero   = 2'h2,
    brbc_sas_one    = 2'h3,
    brbc_sas_invert = 2'h1
  } brbc_sas_t;

  typedef struct packed {
    logic [31:0] start_addr;
    logic [31:0] end_addr;
    logic        enable;
  } brbc_window_t;

  typedef enum logic [2:0] {
    brbc_idle  = 3'b001,
    brbc_write = 3'b010,
    brbc_done  = 3'b100
  } brbc_bank_state_t;
endpackage

// file: src/brbc_ctrl.sv
// Boot region select, boot bank select, code cache and flash clock control behind APB.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "brbc_map.svh"

module brbc_ctrl
  import brbc_pkg::*;
#(
  parameter bit HAS_DUAL_BANK = 1'b1
) (
  input  wire logic        pclk,              // Flash clock, 250 MHz.
  input  wire logic        presetn,           // Asynchronous reset, active low.
  input  wire logic        psel,              // APB select.
  input  wire logic        penable,           // APB access phase.
  input  wire logic        pwrite,            // APB write.
  input  wire logic [11:0] paddr,             // APB byte address.
  input  wire logic [31:0] pwdata,            // APB write data.
  output logic      [31:0] prdata,            // APB read data.
  output logic             pready,            // APB ready.
  output logic             pslverr,           // APB error on unmapped address.
  input  wire logic        opt_swap_flag,     // Option memory startup swap flag, pin.
  input  wire logic        dual_mode,         // Flash in dual-bank mode, pin.
  input  wire logic [31:0] fetch_addr,        // Code flash read address.
  output logic             fetch_cacheable,   // Current read may use the cache.
  output logic             cache_active,      // Cache presently in use.
  output logic             boot_region_one,   // Startup region 1 is active.
  output logic             boot_bank_one,     // Bank 1 is active since reset.
  output logic [1:0]       df_read_wait,      // Data flash read wait states.
  output logic             flash_ready_irq    // Level interrupt output.
);

  logic [1:0]  opt_sync;
  logic [1:0]  dual_sync;
  logic        opt_swap;
  logic        dual;
  brbc_sas_t   startup_area_select;
  logic        cache_en;
  logic        cache_hold;
  logic [2:0]  hold_cnt;
  brbc_window_t win [2];
  logic [1:0]  in_win;
  logic        boot_bank_select_reg;
  logic        bank_latched;
  logic        bank_captured;
  brbc_bank_state_t bank_state;
  logic [3:0]  bank_cnt;
  logic [7:0]  flash_seq_clock;
  logic [`BRBC_IRQ_W-1:0] irq_stat;
  logic [`BRBC_IRQ_W-1:0] irq_mask;
  logic [`BRBC_IRQ_W-1:0] irq_event;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        region_base_one;
  logic        next_region_one;
  logic [31:0] next_prdata;
  logic [1:0]  next_df_wait;

  assign opt_swap = opt_sync[1];
  assign dual     = dual_sync[1];
  assign wr_en    = psel && penable && pwrite && pready;
  assign rd_en    = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_sync  <= 2'h3;
      dual_sync <= 2'h0;
    end else begin
      opt_sync  <= {opt_sync[0], opt_swap_flag};
      dual_sync <= {dual_sync[0], dual_mode};
    end
  end

  always_comb begin
    addr_ok = 1'b1;
    unique case (paddr)
      `BRBC_OFF_SUACR, `BRBC_OFF_CACHE_CTRL, `BRBC_OFF_CACHE_STAT, `BRBC_OFF_WIN_A_START,
      `BRBC_OFF_WIN_A_END, `BRBC_OFF_WIN_B_START, `BRBC_OFF_WIN_B_END, `BRBC_OFF_WIN_EN,
      `BRBC_OFF_BOOT_BANK_SELECT_REG, `BRBC_OFF_CLK_MHZ, `BRBC_OFF_DF_WAIT, `BRBC_OFF_IRQ_STAT,
      `BRBC_OFF_IRQ_MASK, `BRBC_OFF_BOOT_STAT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answers one cycle after setup: pready rises in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        prdata <= next_prdata;
      end else if (!psel) begin
        prdata <= 32'h0;
      end
    end
  end

  assign region_base_one = !opt_swap;

  always_comb begin
    unique case (startup_area_select)
      brbc_sas_follow: next_region_one = region_base_one;
      brbc_sas_zero:   next_region_one = 1'b0;
      brbc_sas_one:    next_region_one = 1'b1;
      brbc_sas_invert: next_region_one = !region_base_one;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_area_select <= brbc_sas_follow;
    end else if (wr_en && paddr == `BRBC_OFF_SUACR && !dual) begin
      startup_area_select <= brbc_sas_t'(pwdata[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_region_one <= 1'b0;
    end else begin
      boot_region_one <= next_region_one;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_win
      assign in_win[gi] = win[gi].enable && fetch_addr >= win[gi].start_addr
                          && fetch_addr <= win[gi].end_addr;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          win[gi] <= '0;
        end else if (wr_en) begin
          if (paddr == `BRBC_OFF_WIN_A_START + 12'(gi * 8)) begin
            win[gi].start_addr <= pwdata;
          end
          if (paddr == `BRBC_OFF_WIN_A_END + 12'(gi * 8)) begin
            win[gi].end_addr <= pwdata;
          end
          if (paddr == `BRBC_OFF_WIN_EN) begin
            win[gi].enable <= pwdata[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_en <= 1'b0;
    end else if (wr_en && paddr == `BRBC_OFF_CACHE_CTRL) begin
      cache_en <= pwdata[0];
    end
  end

  // Cache held off while windows change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_hold <= 1'b0;
      hold_cnt   <= 3'h0;
    end else if (wr_en && cache_en && paddr >= `BRBC_OFF_WIN_A_START
                 && paddr <= `BRBC_OFF_WIN_EN) begin
      cache_hold <= 1'b1;
      hold_cnt   <= 3'(`BRBC_CACHE_HOLD_CYC);
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end else begin
      cache_hold <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_active    <= 1'b0;
      fetch_cacheable <= 1'b0;
    end else begin
      cache_active    <= cache_en && !cache_hold;
      fetch_cacheable <= cache_en && !cache_hold && (in_win == 2'h0);
    end
  end

  // Active bank is caught from the inverse of the select register at the first edge after reset.
  // Never applied: reset reloads the select register default, so bank 0 is always caught.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_captured <= 1'b0;
      bank_latched  <= 1'b0;
    end else if (!bank_captured) begin
      bank_captured <= 1'b1;
      bank_latched  <= !boot_bank_select_reg;
    end
  end

  assign boot_bank_one = bank_latched;

  // Select register survives reset in the real array; here it reloads its default.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_state           <= brbc_idle;
      bank_cnt             <= 4'h0;
      boot_bank_select_reg <= `BRBC_BOOT_BANK_SELECT_REG_RESET;
    end else begin
      unique case (bank_state)
        brbc_idle: begin
          if (wr_en && paddr == `BRBC_OFF_BOOT_BANK_SELECT_REG && dual && HAS_DUAL_BANK) begin
            bank_state <= brbc_write;
            bank_cnt   <= 4'(`BRBC_BANK_WRITE_CYC);
            boot_bank_select_reg <= pwdata[0];
          end
        end
        brbc_write: begin
          if (bank_cnt == 4'h1) begin
            bank_state <= brbc_done;
          end
          bank_cnt <= bank_cnt - 4'h1;
        end
        brbc_done: bank_state <= brbc_idle;
      endcase
    end
  end

  always_comb begin
    if (flash_seq_clock > `BRBC_DF_THRESH3) begin
      next_df_wait = 2'h3;
    end else if (flash_seq_clock > `BRBC_DF_THRESH2) begin
      next_df_wait = 2'h2;
    end else if (flash_seq_clock > `BRBC_DF_THRESH1) begin
      next_df_wait = 2'h1;
    end else begin
      next_df_wait = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_seq_clock <= `BRBC_CLK_RESET;
      df_read_wait    <= `BRBC_DF_WAIT_RESET;
    end else begin
      if (wr_en && paddr == `BRBC_OFF_CLK_MHZ) begin
        flash_seq_clock <= pwdata[7:0];
      end
      df_read_wait <= next_df_wait;
    end
  end

  // Ready event on bank write done.
  assign irq_event[`BRBC_IRQ_BANK_DONE] = (bank_state == brbc_done);
  assign irq_event[`BRBC_IRQ_CLK_DONE]  = wr_en && paddr == `BRBC_OFF_CLK_MHZ;

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat        <= '0;
      irq_mask        <= '0;
      flash_ready_irq <= 1'b0;
    end else begin
      if (wr_en && paddr == `BRBC_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~pwdata[`BRBC_IRQ_W-1:0]) | irq_event;
      end else begin
        irq_stat <= irq_stat | irq_event;
      end
      if (wr_en && paddr == `BRBC_OFF_IRQ_MASK) begin
        irq_mask <= pwdata[`BRBC_IRQ_W-1:0];
      end
      flash_ready_irq <= |(irq_stat & irq_mask);
    end
  end

  always_comb begin
    next_prdata = 32'h0;
    unique case (paddr)
      `BRBC_OFF_SUACR:       next_prdata = {30'h0, startup_area_select};
      `BRBC_OFF_CACHE_CTRL:  next_prdata = {31'h0, cache_en};
      `BRBC_OFF_CACHE_STAT:  next_prdata = {31'h0, cache_en};
      `BRBC_OFF_WIN_A_START: next_prdata = win[0].start_addr;
      `BRBC_OFF_WIN_A_END:   next_prdata = win[0].end_addr;
      `BRBC_OFF_WIN_B_START: next_prdata = win[1].start_addr;
      `BRBC_OFF_WIN_B_END:   next_prdata = win[1].end_addr;
      `BRBC_OFF_WIN_EN:      next_prdata = {30'h0, win[1].enable, win[0].enable};
      `BRBC_OFF_BOOT_BANK_SELECT_REG:     next_prdata = {31'h0, boot_bank_select_reg};
      `BRBC_OFF_CLK_MHZ:     next_prdata = {24'h0, flash_seq_clock};
      `BRBC_OFF_DF_WAIT:     next_prdata = {30'h0, df_read_wait};
      `BRBC_OFF_IRQ_STAT:    next_prdata = {30'h0, irq_stat};
      `BRBC_OFF_IRQ_MASK:    next_prdata = {30'h0, irq_mask};
      `BRBC_OFF_BOOT_STAT:   next_prdata = {28'h0, bank_state != brbc_idle, dual,
                                            boot_bank_one, boot_region_one};
      default:               next_prdata = 32'h0;
    endcase
  end

endmodule // brbc_ctrl
`default_nettype wire

// file: verification/brbc_ctrl_props.sv
// Concurrent checks on the ports of the boot region, bank and cache control.
`timescale 1ns/1ps
`default_nettype none
module brbc_ctrl_props (
  input wire logic        pclk,            // Clock.
  input wire logic        presetn,         // Reset, active low.
  input wire logic        psel,            // APB select.
  input wire logic        penable,         // APB enable.
  input wire logic        pwrite,          // APB write.
  input wire logic [11:0] paddr,           // APB address.
  input wire logic [31:0] pwdata,          // APB write data.
  input wire logic        pready,          // APB ready.
  input wire logic        pslverr,         // APB error.
  input wire logic        dual_mode,       // Dual-bank mode pin.
  input wire logic        fetch_cacheable, // Read may use the cache.
  input wire logic        cache_active,    // Cache in use.
  input wire logic        boot_region_one, // Region 1 active.
  input wire logic        boot_bank_one,   // Bank 1 active.
  input wire logic [1:0]  df_read_wait     // Data flash wait states.
);
  logic       wr;
  logic       lin;
  logic [3:0] dhist;
  assign wr  = psel && penable && pready && pwrite;
  assign lin = (dhist == 4'h0) && !dual_mode;
  // The mode pin passes a synchroniser, so linear mode counts only once it has settled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dhist <= 4'hf;
    else dhist <= {dhist[2:0], dual_mode};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_single; pready |-> psel && penable ##1 !pready; endproperty
  a_single: assert property (p_single) else $error("ready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_fetch; fetch_cacheable |-> cache_active; endproperty
  a_fetch: assert property (p_fetch) else $error("cacheable while cache off");
  property p_hold;
    wr && cache_active && paddr inside {[12'h00c:12'h01c]} |-> ##2 !cache_active [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("cache not held off");
  property p_force0; wr && paddr == 12'h000 && pwdata[1:0] == 2'h2 && lin |-> ##2 !boot_region_one;
  endproperty
  a_force0: assert property (p_force0) else $error("region 0 not forced");
  property p_force1; wr && paddr == 12'h000 && pwdata[1:0] == 2'h3 && lin |-> ##2 boot_region_one;
  endproperty
  a_force1: assert property (p_force1) else $error("region 1 not forced");
  property p_bank; $past(presetn, 2) |-> $stable(boot_bank_one); endproperty
  a_bank: assert property (p_bank) else $error("bank changed without reset");
  property p_dfhi; wr && paddr == 12'h024 && pwdata[7:0] > 8'h50 |-> ##2 df_read_wait == 2'h3;
  endproperty
  a_dfhi: assert property (p_dfhi) else $error("fast clock wait wrong");
  property p_dflo; wr && paddr == 12'h024 && pwdata[7:0] <= 8'h20 |-> ##2 df_read_wait == 2'h0;
  endproperty
  a_dflo: assert property (p_dflo) else $error("slow clock wait wrong");
endmodule // brbc_ctrl_props

bind brbc_ctrl brbc_ctrl_props brbc_ctrl_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .dual_mode(dual_mode), .fetch_cacheable(fetch_cacheable),
  .cache_active(cache_active), .boot_region_one(boot_region_one),
  .boot_bank_one(boot_bank_one), .df_read_wait(df_read_wait));
`default_nettype wire

// file: verification/tb_top.sv
// Register-level testbench for the boot region, bank and cache control.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        opt_swap_flag = 1'b1, dual_mode = 1'b0, pready, pslverr, e;
  logic        fetch_cacheable, cache_active, boot_region_one, boot_bank_one, flash_ready_irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, fetch_addr = 32'h0, prdata, q;
  logic [1:0]  df_read_wait;
  int          err_count = 0, checks = 0, i;
  logic [11:0] ra [7] = '{12'h000, 12'h004, 12'h008, 12'h020, 12'h024, 12'h028, 12'h030};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h20, 32'h0, 32'h0};
  logic [3:0]  rt [8] = '{4'h8, 4'hc, 4'hf, 4'hb, 4'h1, 4'h2, 4'h7, 4'h4};
  logic [7:0]  cv [6] = '{8'h21, 8'h3c, 8'h3d, 8'h50, 8'h51, 8'h20};
  logic [1:0]  cw [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};

  brbc_ctrl brbc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opt_swap_flag(opt_swap_flag), .dual_mode(dual_mode),
    .fetch_addr(fetch_addr), .fetch_cacheable(fetch_cacheable), .cache_active(cache_active),
    .boot_region_one(boot_region_one), .boot_bank_one(boot_bank_one),
    .df_read_wait(df_read_wait), .flash_ready_irq(flash_ready_irq));

  always #2 pclk = ~pclk;

  task give_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Ready and read data are taken at the rising edge, before the design's updates of that edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), ex, q);
  endtask

  task wt(input int n);
    repeat (n) @(negedge pclk);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wt(4);
    chk("df_read_wait", 32'h0, {30'h0, df_read_wait});
    chk("boot_bank_one", 32'h0, {31'h0, boot_bank_one});
    for (i = 0; i < 7; i++) rd(ra[i], rv[i]);
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      opt_swap_flag <= rt[i][3];
      apb(1'b1, 12'h000, {30'h0, rt[i][2:1]});
      wt(5);
      chk("boot_region_one", {31'h0, rt[i][0]}, {31'h0, boot_region_one});
      rd(12'h000, {30'h0, rt[i][2:1]});
    end
    @(posedge pclk);
    dual_mode <= 1'b1;
    wt(4);
    apb(1'b1, 12'h000, 32'h3);
    rd(12'h000, 32'h2);
    apb(1'b1, 12'h020, 32'h0);
    apb(1'b1, 12'h020, 32'h1);
    rd(12'h020, 32'h0);
    wt(14);
    chk("irq masked", 32'h0, {31'h0, flash_ready_irq});
    rd(12'h02c, 32'h1);
    apb(1'b1, 12'h030, 32'h1);
    wt(2);
    chk("irq", 32'h1, {31'h0, flash_ready_irq});
    apb(1'b1, 12'h02c, 32'h1);
    wt(2);
    chk("irq cleared", 32'h0, {31'h0, flash_ready_irq});
    chk("boot_bank_one", 32'h0, {31'h0, boot_bank_one});
    @(posedge pclk);
    dual_mode <= 1'b0;
    wt(4);
    apb(1'b1, 12'h020, 32'h1);
    rd(12'h020, 32'h0);
    for (i = 0; i < 6; i++) begin
      apb(1'b1, 12'h024, {24'h0, cv[i]});
      wt(3);
      chk("df_read_wait", {30'h0, cw[i]}, {30'h0, df_read_wait});
      rd(12'h028, {30'h0, cw[i]});
    end
    rd(12'h02c, 32'h2);
    chk("irq masked", 32'h0, {31'h0, flash_ready_irq});
    apb(1'b1, 12'h004, 32'h1);
    wt(3);
    chk("cache_active", 32'h1, {31'h0, cache_active});
    rd(12'h008, 32'h1);
    apb(1'b1, 12'h00c, 32'h100);
    apb(1'b1, 12'h010, 32'h1ff);
    apb(1'b1, 12'h01c, 32'h1);
    wt(2);
    chk("cache held", 32'h0, {31'h0, cache_active});
    apb(1'b1, 12'h014, 32'h300);
    apb(1'b1, 12'h018, 32'h3ff);
    apb(1'b1, 12'h01c, 32'h3);
    wt(8);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      fetch_addr <= (i < 2) ? 32'h150 + 32'hb0 * i : 32'h3fd + i;
      wt(3);
      chk("fetch_cacheable", {31'h0, i[0]}, {31'h0, fetch_cacheable});
    end
    rd(12'h00c, 32'h100);
    rd(12'h018, 32'h3ff);
    apb(1'b1, 12'h004, 32'h0);
    rd(12'h008, 32'h0);
    chk("cache_active", 32'h0, {31'h0, cache_active});
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h040, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    give_verdict();
  end

  initial begin
    repeat (4000) @(posedge pclk);
    err_count++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
